// file: hdl/vlsms_decode.sv
`timescale 1ns/1ns

module vlsms_decode
  import vlsms_pkg::*;
(
  // Configuration byte in force for the line.
  input wire logic [7:0] cfg,
  // Decoded controls.
  output logic active,
  output logic [3:0] code,
  output logic teletext,
  output logic caption,
  output logic null_filter_en,
  output logic data_filter_en,
  output logic to_fifo,
  output logic to_regs,
  output logic block_errored,
  output logic ecc_en
);

  // Splits a configuration byte into the controls of the slicing engines.
  always_comb begin
    code = cfg[3:0];
    active = (cfg[3:0] != STD_OFF);
    teletext = (cfg[3:0] <= STD_JAPAN_TELETEXT);
    caption = (cfg[3:0] == STD_CC_PAL) || (cfg[3:0] == STD_CC_NTSC);
    null_filter_en = caption && cfg[BIT_FILTER];
    data_filter_en = teletext && cfg[BIT_FILTER];
    to_fifo = active && cfg[BIT_ROUTE];
    to_regs = active && !(teletext && cfg[BIT_ROUTE]);
    block_errored = cfg[BIT_ERR_GATE];
    ecc_en = cfg[BIT_ECC];
  end

endmodule : vlsms_decode

// file: hdl/vlsms_pkg.sv
package vlsms_pkg;

  // ********************************************************************
  // Register map.
  // ********************************************************************
  localparam logic [7:0] ADDR_FULL_EN = 8'hCF;
  localparam logic [7:0] ADDR_LINE_BASE = 8'hD0;
  localparam logic [7:0] ADDR_LINE_LAST = 8'hFB;
  localparam logic [7:0] ADDR_FULL_MODE = 8'hFC;

  // ********************************************************************
  // Reset values.
  // ********************************************************************
  localparam logic [7:0] RST_FULL_MODE = 8'h7F;
  localparam logic [7:0] RST_LINE_FIRST = 8'h00;
  localparam logic [7:0] RST_LINE = 8'hFF;
  localparam logic RST_FULL_EN = 1'b0;
  localparam logic [7:0] CFG_USE_FULL = 8'hFF;

  // ********************************************************************
  // Line coverage of the per-line table.
  // ********************************************************************
  localparam logic [9:0] LINE_FIRST = 10'h006;
  localparam logic [9:0] LINE_LAST = 10'h01B;
  localparam int NUM_LINE_CFG = 44;

  // ********************************************************************
  // Field positions of a configuration byte.
  // ********************************************************************
  localparam int BIT_FILTER = 7;
  localparam int BIT_ROUTE = 6;
  localparam int BIT_ERR_GATE = 5;
  localparam int BIT_ECC = 4;
  localparam int BIT_FULL_EN = 0;

  // ********************************************************************
  // Slicing standard codes.
  // ********************************************************************
  localparam logic [3:0] STD_WST_SECAM = 4'h0;
  localparam logic [3:0] STD_WST_PAL_B = 4'h1;
  localparam logic [3:0] STD_WST_PAL_C = 4'h2;
  localparam logic [3:0] STD_WST_NTSC = 4'h3;
  localparam logic [3:0] STD_NABTS_NTSC = 4'h4;
  localparam logic [3:0] STD_JAPAN_TELETEXT = 4'h5;
  localparam logic [3:0] STD_CC_PAL = 4'h6;
  localparam logic [3:0] STD_CC_NTSC = 4'h7;
  localparam logic [3:0] STD_WSS_PAL = 4'h8;
  localparam logic [3:0] STD_WSS_NTSC = 4'h9;
  localparam logic [3:0] STD_VITC_PAL = 4'hA;
  localparam logic [3:0] STD_VITC_NTSC = 4'hB;
  localparam logic [3:0] STD_VPS_PAL = 4'hC;
  localparam logic [3:0] STD_CUSTOM_1 = 4'hD;
  localparam logic [3:0] STD_CUSTOM_2 = 4'hE;
  localparam logic [3:0] STD_OFF = 4'hF;

endpackage : vlsms_pkg

// file: hdl/vlsms_top.sv
`timescale 1ns/1ns
// What this block does
// - Caption lines drop null bytes when filter set.
// - Teletext lines use data filter when set.
// - Routing bit picks registers, both, or FIFO.
// - Error-gate bit keeps errored data from FIFO.
// - Correction bit enables error detection and correction.
// - Codes zero to five select teletext kinds.
// - Codes six to nine select caption, WSS.
// - Codes ten to fourteen select VITC, VPS, custom.
// - Code fifteen means no slicing, the default.
// - Only all-ones line byte uses full-field mode.
// - Full-field register uses same byte layout.
// - Other line bytes override the full-field register.
// - Full-field register resets to 7Fh.
// - Full-field enable covers non-blanking and all-ones lines.
// - Line bytes for 6..27 both fields, reset values.

module vlsms_top
  import vlsms_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Video timing from the decoder core.
  input wire logic line_start,
  input wire logic [9:0] line_number,
  input wire logic field_id,
  // Controls for the slicing engines.
  output logic slice_active,
  output logic [3:0] slice_code,
  output logic slice_teletext,
  output logic slice_caption,
  output logic null_filter_en,
  output logic data_filter_en,
  output logic send_to_fifo,
  output logic send_to_regs,
  output logic block_errored,
  output logic ecc_en,
  output logic using_full_field
);

  // ********************************************************************
  // State.
  // ********************************************************************
  typedef struct packed {
    logic [NUM_LINE_CFG-1:0][7:0] line_cfg;
    logic [7:0] full_mode;
    logic full_en;
    logic [7:0] rdata;
    logic active;
    logic [3:0] code;
    logic teletext;
    logic caption;
    logic null_filter;
    logic data_filter;
    logic to_fifo;
    logic to_regs;
    logic block_err;
    logic ecc;
    logic use_full;
  } vlsms_state_type;

  vlsms_state_type st;
  vlsms_state_type next_st;
  logic [9:0] line_off;
  logic [5:0] line_idx;
  logic in_vbi;
  logic [7:0] own_cfg;
  logic pick_full;
  logic [7:0] sel_cfg;
  logic [7:0] addr_off;
  logic [5:0] addr_idx;
  logic addr_line;
  logic d_active;
  logic [3:0] d_code;
  logic d_teletext;
  logic d_caption;
  logic d_null_filter;
  logic d_data_filter;
  logic d_to_fifo;
  logic d_to_regs;
  logic d_block_err;
  logic d_ecc;

  // Locates the table entry of the current line and chooses its configuration.
  always_comb begin
    line_off = line_number - LINE_FIRST;
    line_idx = {line_off[4:0], field_id};
    in_vbi = (line_number >= LINE_FIRST) && (line_number <= LINE_LAST);
    own_cfg = in_vbi ? st.line_cfg[line_idx] : CFG_USE_FULL;
    pick_full = (own_cfg == CFG_USE_FULL);
    if (pick_full) begin
      sel_cfg = st.full_en ? st.full_mode : CFG_USE_FULL;
    end else begin
      sel_cfg = own_cfg;
    end
    addr_off = reg_addr - ADDR_LINE_BASE;
    addr_idx = addr_off[5:0];
    addr_line = (reg_addr >= ADDR_LINE_BASE) && (reg_addr <= ADDR_LINE_LAST);
  end

  // Decodes the chosen byte into engine controls.
  vlsms_decode u_decode (
    .cfg(sel_cfg),
    .active(d_active),
    .code(d_code),
    .teletext(d_teletext),
    .caption(d_caption),
    .null_filter_en(d_null_filter),
    .data_filter_en(d_data_filter),
    .to_fifo(d_to_fifo),
    .to_regs(d_to_regs),
    .block_errored(d_block_err),
    .ecc_en(d_ecc)
  );

  // Handles register access and updates the line controls at line start.
  always_comb begin
    next_st = st;
    if (reg_write) begin
      if (addr_line) begin
        next_st.line_cfg[addr_idx] = reg_wdata;
      end else if (reg_addr == ADDR_FULL_MODE) begin
        next_st.full_mode = reg_wdata;
      end else if (reg_addr == ADDR_FULL_EN) begin
        next_st.full_en = reg_wdata[BIT_FULL_EN];
      end
    end
    if (reg_read) begin
      if (addr_line) begin
        next_st.rdata = st.line_cfg[addr_idx];
      end else if (reg_addr == ADDR_FULL_MODE) begin
        next_st.rdata = st.full_mode;
      end else if (reg_addr == ADDR_FULL_EN) begin
        next_st.rdata = {7'h00, st.full_en};
      end else begin
        next_st.rdata = 8'h00;
      end
    end
    if (line_start) begin
      next_st.active = d_active;
      next_st.code = d_code;
      next_st.teletext = d_teletext;
      next_st.caption = d_caption;
      next_st.null_filter = d_null_filter;
      next_st.data_filter = d_data_filter;
      next_st.to_fifo = d_to_fifo;
      next_st.to_regs = d_to_regs;
      next_st.block_err = d_block_err;
      next_st.ecc = d_ecc;
      next_st.use_full = pick_full && st.full_en;
    end
  end

  // Registers the state; reset loads the documented defaults.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
      for (int i = 0; i < NUM_LINE_CFG; i++) begin
        st.line_cfg[i] <= (i == 0) ? RST_LINE_FIRST : RST_LINE;
      end
      st.full_mode <= RST_FULL_MODE;
      st.full_en <= RST_FULL_EN;
      st.code <= STD_OFF;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state flops.
  assign reg_rdata = st.rdata;
  assign slice_active = st.active;
  assign slice_code = st.code;
  assign slice_teletext = st.teletext;
  assign slice_caption = st.caption;
  assign null_filter_en = st.null_filter;
  assign data_filter_en = st.data_filter;
  assign send_to_fifo = st.to_fifo;
  assign send_to_regs = st.to_regs;
  assign block_errored = st.block_err;
  assign ecc_en = st.ecc;
  assign using_full_field = st.use_full;

  // ********************************************************************
  // Checks.
  // ********************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  full_reset_a: assert property (disable iff (1'b0) !rst_n |=>
    (st.full_mode == RST_FULL_MODE && st.line_cfg[0] == RST_LINE_FIRST))
    else $error("Full-field or first line byte reset value wrong.");
  own_line_a: assert property (line_start && in_vbi && own_cfg != CFG_USE_FULL |=>
    slice_code == $past(own_cfg[3:0]) && !using_full_field)
    else $error("Programmed line did not use its own byte.");
  full_used_a: assert property (line_start && !in_vbi && st.full_en |=>
    slice_code == $past(st.full_mode[3:0]) && using_full_field)
    else $error("Full-field setting not applied outside blanking.");
  full_off_a: assert property (line_start && pick_full && !st.full_en |=>
    !slice_active ##1 ($past(line_start) || !slice_active))
    else $error("Slicing without full-field enable.");
  code_off_a: assert property (slice_active |-> slice_code != STD_OFF)
    else $error("Inactive code reported as active.");
  null_filter_a: assert property (null_filter_en |-> slice_caption)
    else $error("Null filter outside caption mode.");
  ttx_route_a: assert property (slice_teletext && send_to_fifo |-> !send_to_regs)
    else $error("Teletext routed to registers with FIFO route.");
  ttx_kind_a: assert property (slice_teletext |-> slice_code <= STD_JAPAN_TELETEXT)
    else $error("Teletext flag on non-teletext code.");
  hold_line_a: assert property (!line_start |=> $stable(slice_code) && $stable(ecc_en))
    else $error("Line controls changed mid-line.");
  readback_a: assert property ((reg_write && reg_addr == ADDR_FULL_MODE && !reg_read) ##1
    (reg_read && !reg_write && reg_addr == ADDR_FULL_MODE) |=>
    reg_rdata == $past(reg_wdata, 2))
    else $error("Full-field register readback wrong.");

  ttx_line_c: cover property (line_start ##1 slice_teletext && data_filter_en);
  cc_line_c: cover property (line_start ##1 slice_caption && null_filter_en);
  full_line_c: cover property (line_start ##1 using_full_field && slice_active);

endmodule : vlsms_top

// file: testbench/vlsms_top_tb.sv
`timescale 1ns/1ns
`define CHK(got, exp, msg) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp); \
    end \
  end

module vlsms_top_tb
  import vlsms_pkg::*;
;
  // ****************************************************************
  // Signals and bench model state.
  // ****************************************************************
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic line_start = 1'b0;
  logic [9:0] line_number = 10'h000;
  logic field_id = 1'b0;
  logic [7:0] reg_rdata;
  logic slice_active, slice_teletext, slice_caption, null_filter_en, data_filter_en;
  logic send_to_fifo, send_to_regs, block_errored, ecc_en, using_full_field;
  logic [3:0] slice_code;
  logic [11:0] got, exp_v;
  logic [7:0] tbl [NUM_LINE_CFG];
  logic [7:0] full_mode;
  logic full_en;
  int n_mismatch = 0;
  int tests_run = 0;

  assign got = {slice_active, slice_code, slice_teletext, slice_caption, null_filter_en,
                data_filter_en, send_to_fifo, send_to_regs, using_full_field};

  vlsms_top i_vlsms_top (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .line_start(line_start), .line_number(line_number),
    .field_id(field_id), .slice_active(slice_active), .slice_code(slice_code),
    .slice_teletext(slice_teletext), .slice_caption(slice_caption),
    .null_filter_en(null_filter_en), .data_filter_en(data_filter_en),
    .send_to_fifo(send_to_fifo), .send_to_regs(send_to_regs),
    .block_errored(block_errored), .ecc_en(ecc_en), .using_full_field(using_full_field));

  // The clock toggles every half period of 10 ns.
  initial begin
    forever #10 mclk = ~mclk;
  end

  // ****************************************************************
  // Model, bus tasks and closing report.
  // ****************************************************************
  // Loads the documented reset contents into the model.
  task automatic init_model();
    foreach (tbl[i]) tbl[i] = RST_LINE;
    tbl[0] = RST_LINE_FIRST;
    full_mode = RST_FULL_MODE;
    full_en = RST_FULL_EN;
  endtask : init_model

  // Returns what a read of an address must give.
  function automatic logic [7:0] model_rd(logic [7:0] a);
    if (a >= ADDR_LINE_BASE && a <= ADDR_LINE_LAST) return tbl[a - ADDR_LINE_BASE];
    if (a == ADDR_FULL_MODE) return full_mode;
    if (a == ADDR_FULL_EN) return {7'h00, full_en};
    return 8'h00;
  endfunction : model_rd

  // Writes one byte and mirrors it in the model.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge mclk);
    reg_write = 1'b0;
    if (a >= ADDR_LINE_BASE && a <= ADDR_LINE_LAST) tbl[a - ADDR_LINE_BASE] = d;
    if (a == ADDR_FULL_MODE) full_mode = d;
    if (a == ADDR_FULL_EN) full_en = d[BIT_FULL_EN];
  endtask : wr

  // Reads one byte and compares it with the model.
  task automatic rd(logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge mclk);
    reg_read = 1'b0;
    `CHK(reg_rdata, model_rd(a), "register read")
  endtask : rd

  // Starts a line and compares every slice control with the model.
  task automatic lcheck(int n, int f);
    logic [7:0] cfg;
    logic uf, act, ttx, cap;
    cfg = (n >= 6 && n <= 27) ? tbl[(n - 6) * 2 + f] : CFG_USE_FULL;
    uf = full_en && cfg == CFG_USE_FULL;
    if (uf) cfg = full_mode;
    act = cfg[3:0] != STD_OFF;
    ttx = cfg[3:0] <= STD_JAPAN_TELETEXT;
    cap = cfg[3:0] == STD_CC_PAL || cfg[3:0] == STD_CC_NTSC;
    exp_v = {act, cfg[3:0], ttx, cap, cap & cfg[7], ttx & cfg[7], act & cfg[6],
             act & ~(ttx & cfg[6]), uf};
    @(negedge mclk);
    line_start = 1'b1;
    line_number = 10'(n);
    field_id = 1'(f);
    @(negedge mclk);
    line_start = 1'b0;
    `CHK(got, exp_v, "line controls")
    `CHK({block_errored, ecc_en}, cfg[5:4], "error bits")
  endtask : lcheck

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Cuts a hung run short and counts it as a mismatch.
  initial begin
    #400000;
    n_mismatch++;
    $display("unexpected at %0t: run limit reached", $time);
    complete_run();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    void'($urandom(32'h7A5D));
    init_model();
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    for (int a = 'hCE; a <= 'hFF; a++) rd(8'(a));
    $display("test reset values done");
    for (int n = 4; n <= 29; n++) for (int f = 0; f < 2; f++) lcheck(n, f);
    $display("test default lines done");
    for (int c = 0; c < 16; c++) begin
      wr(8'(ADDR_LINE_BASE + 2 * c), {4'($urandom), 4'(c)});
      lcheck(6 + c, 0);
      wr(ADDR_FULL_MODE, {4'($urandom), 4'(c)});
      wr(ADDR_FULL_EN, 8'(c));
      lcheck(300, 1);
      lcheck(27, 1);
      lcheck(6 + c, 0);
    end
    $display("test codes and full field done");
    lcheck(21, 0);
    wr(8'hEE, 8'h36);
    `CHK(got, exp_v, "held controls")
    lcheck(21, 0);
    $display("test line hold done");
    // A read straight after a write must return the new full-field byte.
    @(negedge mclk);
    reg_addr = ADDR_FULL_MODE;
    reg_wdata = 8'($urandom);
    reg_write = 1'b1;
    @(negedge mclk);
    reg_write = 1'b0;
    reg_read = 1'b1;
    full_mode = reg_wdata;
    @(negedge mclk);
    reg_read = 1'b0;
    `CHK(reg_rdata, full_mode, "back to back readback")
    $display("test back to back done");
    repeat (400) begin
      case ($urandom_range(2))
        0: wr(8'($urandom_range(255, 192)), 8'($urandom));
        1: rd(8'($urandom_range(255, 192)));
        default: lcheck($urandom_range(40), $urandom_range(1));
      endcase
    end
    $display("test random traffic done");
    @(negedge mclk);
    rst_n = 1'b0;
    @(negedge mclk);
    rst_n = 1'b1;
    init_model();
    `CHK(got, {1'b0, STD_OFF, 7'h00}, "reset controls")
    rd(ADDR_FULL_MODE);
    rd(8'hD0);
    $display("test second reset done");
    complete_run();
  end

endmodule : vlsms_top_tb
